// ===== tcr_map.vh
// Purpose: Offsets, field positions, reset values and counts for the
//          timer compare and periodic interrupt block.
// Assumes: 8-bit register port, one byte per offset.
// Notes:   Definitions only.
// Function
// [R1] A force bit performs the channel pin action but sets no flag.
// [R2] Forced actions take effect at the next counter transition.
// [R3] Software should not force a channel set to toggle.
// [R4] Mask bits 7..3 map to port A 7..3; low bits read zero.
// [R5] First channel match drives masked data bits onto port A.
// [R6] Counter read-only; high byte read latches low byte for one cycle.
// [R7] Mode/level pair: 00 off, 01 toggle, 10 low, 11 high.
// [R8] Fifth compare works only while shared select is zero.
// [R9] Channel interrupt requested when enable and flag are both one.
// [R10] Shared enable serves capture 4 or compare 5 per shared select.
// [R11] Flags clear only by writing one; zero leaves them.
// [R12] Compare flag sets whenever counter equals compare value.
// [R13] Shared flag set by capture 4 or compare 5 per select.
// [R14] Capture flag sets on each detected active edge.
// [R15] Overflow interrupt requested while flag and enable are one.
// [R16] Prescale select writable once, within 64 cycles of reset.
// [R17] Prescale codes divide counter clock by 1, 4, 8, 16.
// [R18] Overflow flag sets when counter rolls from all ones to zero.
// [R19] Rate codes select 2^13 to 2^16 cycle periodic timeouts.
// [R20] Periodic divider runs freely, stopped only by reset.
// [R21] Each timeout sets periodic flag and may request interrupt.
// [R22] One full period passes after reset before first flag.
// [R23] Periodic flag is bit 6 of second flag register.
// [R24] Periodic base is E divided by 2^13, prescaler independent.
// [R25] Counter increments per prescaled tick from reset and wraps.
`ifndef TCR_MAP_VH
`define TCR_MAP_VH

`define TCR_ADDR_W        5
`define TCR_OFF_FORCE     5'h00
`define TCR_OFF_MPMASK    5'h01
`define TCR_OFF_MPDATA    5'h02
`define TCR_OFF_CNT_HI    5'h03
`define TCR_OFF_CNT_LO    5'h04
`define TCR_OFF_ACTION    5'h05
`define TCR_OFF_CH_EN     5'h06
`define TCR_OFF_CH_FLG    5'h07
`define TCR_OFF_MISC_EN   5'h08
`define TCR_OFF_MISC_FLG  5'h09
`define TCR_OFF_ACC_CTL   5'h0A
`define TCR_OFF_CMP_BASE  5'h0B

`define TCR_CMP_RST       16'hFFFF
`define TCR_CNT_MAX       16'hFFFF
`define TCR_PIN_MASK      8'hF8
`define TCR_MISC_EN_MASK  8'hC3
`define TCR_MISC_FLG_MASK 8'hC0
`define TCR_ACC_CTL_MASK  8'h07

`define TCR_BIT_OVF       7
`define TCR_BIT_PER       6
`define TCR_BIT_SHARED    2
`define TCR_BIT_SHARED_FL 3

`define TCR_PR_WINDOW     7'h40
`define TCR_RTI_BASE_LOG2 13
`define TCR_DIV_W         16

`endif

// ===== tcr_divchain.v
// Purpose: Free-running E-clock divider giving the counter tick and
//          the periodic timeout.
// Assumes: Single clock; reset is the only thing that stops the chain.
// Notes:   Both outputs are decoded from the chain; the tick stays high at prescale code 0, else both are one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
`include "tcr_map.vh"

module tcr_divchain (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire [1:0] i_prescale,
  input  wire [1:0] i_rate,
  output wire       o_count_tick,
  output wire       o_rti_timeout
);

  reg  [`TCR_DIV_W-1:0] div_ff;
  wire [`TCR_DIV_W-1:0] pr_mask;
  wire [`TCR_DIV_W-1:0] rti_mask;

  function [`TCR_DIV_W-1:0] pr_decode;
    input [1:0] code;
    begin
      case (code)
        2'b00:   pr_decode = 16'h0000;
        2'b01:   pr_decode = 16'h0003;
        2'b10:   pr_decode = 16'h0007;
        default: pr_decode = 16'h000F;
      endcase
    end
  endfunction

  // A shared chain keeps the periodic rate untouched by the prescaler.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= div_ff + 16'h0001; // [R20]
    end
  end

  assign pr_mask  = pr_decode(i_prescale);
  assign o_count_tick = ((div_ff & pr_mask) == pr_mask); // [R17]

  // Base 2^13 widened by the rate code; first hit is a full period on.
  assign rti_mask = 16'hFFFF >> (2'd3 - i_rate); // [R19] [R24]
  assign o_rti_timeout = ((div_ff & rti_mask) == rti_mask); // [R22]

endmodule // tcr_divchain
`default_nettype wire

// ===== tcr_top.v
// Purpose: Output compare, flag/mask registers, coherent counter read
//          and periodic interrupt for a 16-bit free-running timer.
// Assumes: Plain register port, read data one cycle after the strobe.
// Notes:   Capture edge detection lies outside; its events arrive as
//          one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
`include "tcr_map.vh"

module tcr_top (
  input  wire                   i_clk,
  input  wire                   i_rst_n,
  input  wire [`TCR_ADDR_W-1:0] i_addr,
  input  wire [7:0]             i_wdata,
  input  wire                   i_wr,
  input  wire                   i_rd,
  input  wire                   i_special_mode,
  input  wire [3:0]             i_cap_event,
  output reg  [7:0]             o_rdata,
  output wire [4:0]             o_oc_pin,
  output wire [4:0]             o_oc_pin_oe,
  output wire                   o_irq_chan,
  output wire                   o_irq_ovf,
  output wire                   o_irq_rti
);

  reg  [15:0] cnt_ff;
  reg         cnt_chg_ff;
  reg  [15:0] cmp_ff [0:4];
  reg  [4:0]  force_pend_ff;
  reg  [7:0]  mp_mask_ff;
  reg  [7:0]  mp_data_ff;
  reg  [7:0]  action_ff;
  reg  [7:0]  ch_en_ff;
  reg  [7:0]  ch_flg_ff;
  reg  [7:0]  misc_en_ff;
  reg  [7:0]  misc_flg_ff;
  reg  [7:0]  acc_ctl_ff;
  reg  [4:0]  pin_ff;
  reg  [7:0]  lo_latch_ff;
  reg         lo_valid_ff;
  reg  [6:0]  cyc_ff;
  reg         pr_done_ff;

  reg  [4:0]  nxt_pin;
  reg  [4:0]  match;
  reg  [7:0]  nxt_rdata;
  reg  [7:0]  ch_set;
  reg  [7:0]  misc_set;
  integer     k_m;
  integer     k_p;
  integer     k_r;
  integer     k_d;

  wire        count_tick;
  wire        rti_timeout;
  wire        shared_sel;
  wire [4:0]  force_fire;
  wire [4:0]  event_any;
  wire        wr_force;
  wire        wr_pr_ok;

  assign shared_sel = acc_ctl_ff[`TCR_BIT_SHARED];

  tcr_divchain u_div (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_prescale    (misc_en_ff[1:0]),
    .i_rate        (acc_ctl_ff[1:0]),
    .o_count_tick  (count_tick),
    .o_rti_timeout (rti_timeout)
  );

  function [0:0] pin_action;
    input [1:0] mode_level;
    input       cur;
    begin
      case (mode_level)
        2'b00:   pin_action = cur;
        2'b01:   pin_action = ~cur;
        2'b10:   pin_action = 1'b0;
        default: pin_action = 1'b1;
      endcase
    end
  endfunction

  function is_wr;
    input [`TCR_ADDR_W-1:0] off;
    begin
      is_wr = i_wr && (i_addr == off);
    end
  endfunction

  // Offset of a compare byte; the sum is cut to the port width on purpose.
  function [`TCR_ADDR_W-1:0] cmp_addr;
    input integer idx;
    input         lo;
    integer       sum;
    begin
      sum      = `TCR_OFF_CMP_BASE + 2*idx + lo;
      cmp_addr = sum[`TCR_ADDR_W-1:0];
    end
  endfunction

  // Free-running counter; the cycle after a step is when matches count.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff     <= 16'h0000;
      cnt_chg_ff <= 1'b0;
    end else begin
      if (count_tick) begin
        cnt_ff <= cnt_ff + 16'h0001; // [R25]
      end
      cnt_chg_ff <= count_tick;
    end
  end

  // Sampling once per counter value stops a slow prescale from firing
  // a toggle on every clock the counter sits on the compare value.
  always @* begin
    for (k_m = 0; k_m < 5; k_m = k_m + 1) begin
      match[4-k_m] = cnt_chg_ff && (cnt_ff == cmp_ff[k_m]); // [R12]
    end
    match[0] = match[0] & ~shared_sel; // [R8]
  end

  assign wr_force   = is_wr(`TCR_OFF_FORCE);
  assign force_fire = force_pend_ff & {5{cnt_chg_ff}}; // [R2]
  assign event_any  = match | (force_fire & {4'hF, ~shared_sel}); // [R1] [R8]

  // Pending forces wait for the next count step; a new write wins.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      force_pend_ff <= 5'h00;
    end else begin
      force_pend_ff <= (force_pend_ff & ~force_fire)
                     | ({5{wr_force}} & i_wdata[7:3]); // [R1]
    end
  end

  // Channels 2..5 apply their own action, then the first channel
  // overrides any masked bit, so it wins a same-cycle collision.
  always @* begin
    nxt_pin = pin_ff;
    for (k_p = 0; k_p < 4; k_p = k_p + 1) begin
      if (event_any[k_p]) begin
        nxt_pin[k_p] = pin_action(action_ff[2*k_p +: 2], pin_ff[k_p]); // [R7]
      end
    end
    if (event_any[4]) begin
      for (k_p = 0; k_p < 5; k_p = k_p + 1) begin
        if (mp_mask_ff[k_p+3]) begin
          nxt_pin[k_p] = mp_data_ff[k_p+3]; // [R5]
        end
      end
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_ff <= 5'h00;
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  assign o_oc_pin       = pin_ff;
  assign o_oc_pin_oe[4] = mp_mask_ff[7];
  assign o_oc_pin_oe[3] = (action_ff[7:6] != 2'b00) | mp_mask_ff[6];
  assign o_oc_pin_oe[2] = (action_ff[5:4] != 2'b00) | mp_mask_ff[5];
  assign o_oc_pin_oe[1] = (action_ff[3:2] != 2'b00) | mp_mask_ff[4];
  assign o_oc_pin_oe[0] = ~shared_sel
                        & ((action_ff[1:0] != 2'b00) | mp_mask_ff[3]); // [R8]

  // Flag sources; a set in the cycle of a clear is kept.
  always @* begin
    ch_set      = 8'h00;
    ch_set[7:3] = match; // [R12]
    ch_set[`TCR_BIT_SHARED_FL] = shared_sel ? i_cap_event[3]
                                            : match[0]; // [R13]
    ch_set[2:0] = i_cap_event[2:0]; // [R14]
    misc_set    = 8'h00;
    misc_set[`TCR_BIT_OVF] = count_tick && (cnt_ff == `TCR_CNT_MAX); // [R18]
    misc_set[`TCR_BIT_PER] = rti_timeout; // [R21] [R23]
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ch_flg_ff   <= 8'h00;
      misc_flg_ff <= 8'h00;
    end else begin
      ch_flg_ff <= (ch_flg_ff
                   & ~({8{is_wr(`TCR_OFF_CH_FLG)}} & i_wdata))
                 | ch_set; // [R11]
      misc_flg_ff <= ((misc_flg_ff
                     & ~({8{is_wr(`TCR_OFF_MISC_FLG)}} & i_wdata))
                   | misc_set) & `TCR_MISC_FLG_MASK; // [R11] [R23]
    end
  end

  // Prescale field: once only, inside the window after reset, unless
  // the part runs in a special mode.
  assign wr_pr_ok = i_special_mode
                  | (~pr_done_ff && (cyc_ff < `TCR_PR_WINDOW)); // [R16]

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc_ff     <= 7'h00;
      pr_done_ff <= 1'b0;
    end else begin
      if (cyc_ff < `TCR_PR_WINDOW) begin
        cyc_ff <= cyc_ff + 7'h01;
      end
      if (is_wr(`TCR_OFF_MISC_EN)) begin
        pr_done_ff <= 1'b1; // [R16]
      end
    end
  end

  // Plain control registers and compare values.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mp_mask_ff <= 8'h00;
      mp_data_ff <= 8'h00;
      action_ff  <= 8'h00;
      ch_en_ff   <= 8'h00;
      misc_en_ff <= 8'h00;
      acc_ctl_ff <= 8'h00;
      for (k_r = 0; k_r < 5; k_r = k_r + 1) begin
        cmp_ff[k_r] <= `TCR_CMP_RST;
      end
    end else begin
      if (is_wr(`TCR_OFF_MPMASK)) begin
        mp_mask_ff <= i_wdata & `TCR_PIN_MASK; // [R4]
      end
      if (is_wr(`TCR_OFF_MPDATA)) begin
        mp_data_ff <= i_wdata & `TCR_PIN_MASK;
      end
      if (is_wr(`TCR_OFF_ACTION)) begin
        action_ff <= i_wdata;
      end
      if (is_wr(`TCR_OFF_CH_EN)) begin
        ch_en_ff <= i_wdata;
      end
      if (is_wr(`TCR_OFF_MISC_EN)) begin
        misc_en_ff[7:6] <= i_wdata[7:6];
        if (wr_pr_ok) begin
          misc_en_ff[1:0] <= i_wdata[1:0]; // [R16]
        end
      end
      if (is_wr(`TCR_OFF_ACC_CTL)) begin
        acc_ctl_ff <= i_wdata & `TCR_ACC_CTL_MASK;
      end
      for (k_r = 0; k_r < 5; k_r = k_r + 1) begin
        if (is_wr(cmp_addr(k_r, 1'b0))) begin
          cmp_ff[k_r][15:8] <= i_wdata;
        end
        if (is_wr(cmp_addr(k_r, 1'b1))) begin
          cmp_ff[k_r][7:0] <= i_wdata;
        end
      end
    end
  end

  // High-byte read freezes the low byte for the very next cycle only.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lo_latch_ff <= 8'h00;
      lo_valid_ff <= 1'b0;
    end else begin
      lo_valid_ff <= i_rd && (i_addr == `TCR_OFF_CNT_HI); // [R6]
      if (i_rd && (i_addr == `TCR_OFF_CNT_HI)) begin
        lo_latch_ff <= cnt_ff[7:0]; // [R6]
      end
    end
  end

  // Read decode; unmapped offsets and the force register read zero.
  always @* begin
    nxt_rdata = 8'h00;
    case (i_addr)
      `TCR_OFF_MPMASK:   nxt_rdata = mp_mask_ff; // [R4]
      `TCR_OFF_MPDATA:   nxt_rdata = mp_data_ff;
      `TCR_OFF_CNT_HI:   nxt_rdata = cnt_ff[15:8];
      `TCR_OFF_CNT_LO:   nxt_rdata = lo_valid_ff ? lo_latch_ff
                                                 : cnt_ff[7:0]; // [R6]
      `TCR_OFF_ACTION:   nxt_rdata = action_ff;
      `TCR_OFF_CH_EN:    nxt_rdata = ch_en_ff;
      `TCR_OFF_CH_FLG:   nxt_rdata = ch_flg_ff;
      `TCR_OFF_MISC_EN:  nxt_rdata = misc_en_ff & `TCR_MISC_EN_MASK;
      `TCR_OFF_MISC_FLG: nxt_rdata = misc_flg_ff;
      `TCR_OFF_ACC_CTL:  nxt_rdata = acc_ctl_ff;
      default: begin
        for (k_d = 0; k_d < 5; k_d = k_d + 1) begin
          if (i_addr == cmp_addr(k_d, 1'b0)) begin
            nxt_rdata = cmp_ff[k_d][15:8];
          end
          if (i_addr == cmp_addr(k_d, 1'b1)) begin
            nxt_rdata = cmp_ff[k_d][7:0];
          end
        end
      end
    endcase
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? nxt_rdata : 8'h00;
    end
  end

  // Bit 3 enable pairs with bit 3 flag, whichever function owns it.
  assign o_irq_chan = |(ch_en_ff & ch_flg_ff); // [R9] [R10]
  assign o_irq_ovf  = misc_en_ff[`TCR_BIT_OVF]
                    & misc_flg_ff[`TCR_BIT_OVF]; // [R15]
  assign o_irq_rti  = misc_en_ff[`TCR_BIT_PER]
                    & misc_flg_ff[`TCR_BIT_PER]; // [R21]

endmodule // tcr_top
`default_nettype wire

// ===== tcr_top_properties.sv
// Purpose: Port-level properties of the timer compare block.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   A flag set can beat a clear, so only non-clears are held.
`timescale 1ns/10ps
`default_nettype none
`include "tcr_map.vh"

module tcr_props (
  input wire logic                   i_clk,
  input wire logic                   i_rst_n,
  input wire logic [`TCR_ADDR_W-1:0] i_addr,
  input wire logic [7:0]             i_wdata,
  input wire logic                   i_wr,
  input wire logic                   i_rd,
  input wire logic [7:0]             o_rdata,
  input wire logic [4:0]             o_oc_pin_oe,
  input wire logic                   o_irq_chan,
  input wire logic                   o_irq_ovf,
  input wire logic                   o_irq_rti
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  rdata_idle_a: assert property (o_rdata != 8'h00 |-> $past(i_rd))
    else $error("read data outside a read");
  force_read_a: assert property (
    i_rd && i_addr == `TCR_OFF_FORCE |=> o_rdata == 8'h00)
    else $error("force register read not zero");
  mask_read_a: assert property (
    i_rd && i_addr == `TCR_OFF_MPMASK |=> o_rdata[2:0] == 3'b000)
    else $error("mask low bits not zero");
  flag2_read_a: assert property (
    i_rd && i_addr == `TCR_OFF_MISC_FLG |=> o_rdata[5:0] == 6'h00)
    else $error("misc flag low bits not zero");
  ovf_kept_a: assert property (
    i_wr && i_addr == `TCR_OFF_MISC_FLG && !i_wdata[7] && o_irq_ovf
    |=> o_irq_ovf) else $error("overflow flag lost on zero write");
  rti_kept_a: assert property (
    i_wr && i_addr == `TCR_OFF_MISC_FLG && !i_wdata[6] && o_irq_rti
    |=> o_irq_rti) else $error("periodic flag lost on zero write");
  chan_kept_a: assert property (
    i_wr && i_addr == `TCR_OFF_CH_FLG && i_wdata == 8'h00 && o_irq_chan
    |=> o_irq_chan) else $error("channel flag lost on zero write");
  ovf_off_a: assert property (
    i_wr && i_addr == `TCR_OFF_MISC_EN && !i_wdata[7] |=> !o_irq_ovf)
    else $error("overflow request while disabled");
  rti_off_a: assert property (
    i_wr && i_addr == `TCR_OFF_MISC_EN && !i_wdata[6] |=> !o_irq_rti)
    else $error("periodic request while disabled");
  chan_off_a: assert property (
    i_wr && i_addr == `TCR_OFF_CH_EN && i_wdata == 8'h00 |=> !o_irq_chan)
    else $error("channel request while disabled");
  shared_oe_a: assert property (
    i_wr && i_addr == `TCR_OFF_ACC_CTL && i_wdata[2] |=> !o_oc_pin_oe[0])
    else $error("fifth pin driven in capture mode");
endmodule // tcr_props

bind tcr_top tcr_props u_props (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .o_oc_pin_oe(o_oc_pin_oe),
  .o_irq_chan(o_irq_chan),
  .o_irq_ovf(o_irq_ovf),
  .o_irq_rti(o_irq_rti)
);
`default_nettype wire

// ===== test_timer_compare_rti.sv
// Purpose: Self-checking bench for the timer compare block.
// Assumes: Prescale divides by 1 until a closing special-mode pass;
//          periodic rate code 0.
// Notes:   Expected times are clocks counted since reset release.
`timescale 1ns/10ps
`default_nettype none
`include "tcr_map.vh"

module test_timer_compare_rti;
  logic                   i_clk;
  logic                   i_rst_n;
  logic                   i_wr;
  logic                   i_rd;
  logic                   i_special_mode;
  logic [`TCR_ADDR_W-1:0] i_addr;
  logic [7:0]             i_wdata;
  logic [7:0]             o_rdata;
  logic [7:0]             hi;
  logic [7:0]             lo;
  logic [7:0]             lo2;
  logic [3:0]             i_cap_event;
  logic [4:0]             o_oc_pin;
  logic [4:0]             o_oc_pin_oe;
  logic                   o_irq_chan;
  logic                   o_irq_ovf;
  logic                   o_irq_rti;
  logic [15:0]            tgt;
  int                     n_fail;
  int                     n_checks;
  int                     cyc;

  tcr_top u_dut (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_special_mode(i_special_mode),
    .i_cap_event(i_cap_event),
    .o_rdata(o_rdata),
    .o_oc_pin(o_oc_pin),
    .o_oc_pin_oe(o_oc_pin_oe),
    .o_irq_chan(o_irq_chan),
    .o_irq_ovf(o_irq_ovf),
    .o_irq_rti(o_irq_rti)
  );

  always #2 i_clk = ~i_clk;

  // The counter and the divider start at release, so cyc tracks both.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      cyc <= 0;
    else
      cyc <= cyc + 1;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata & m, e & m);
  endtask

  task automatic rd_val(input logic [4:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask

  task automatic wait_cyc(input int n);
    while (cyc < n)
      @(posedge i_clk);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (70000) @(posedge i_clk);
    n_fail++;
    stop_test;
  end

  initial begin
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_special_mode = 1'b0;
    i_addr = 5'h00;
    i_wdata = 8'h00;
    i_cap_event = 4'h0;
    n_fail = 0;
    n_checks = 0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    wr(`TCR_OFF_MISC_EN, 8'hC0);
    rd(`TCR_OFF_FORCE, 8'h00, 8'hFF);
    rd(5'h1F, 8'h00, 8'hFF);
    wr(`TCR_OFF_MPMASK, 8'hFF);
    rd(`TCR_OFF_MPMASK, 8'hF8, 8'hFF);
    wr(`TCR_OFF_MPDATA, 8'hA8);
    wr(`TCR_OFF_MISC_EN, 8'hC3);
    rd(`TCR_OFF_MISC_EN, 8'hC0, 8'hFF);
    // Three reads back to back: latched low byte, then a live one.
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= `TCR_OFF_CNT_HI;
    @(posedge i_clk);
    i_addr <= `TCR_OFF_CNT_LO;
    #1 hi = o_rdata;
    @(posedge i_clk);
    #1 lo = o_rdata;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 lo2 = o_rdata;
    chk(lo2, lo + 8'd2);
    tgt = {hi, lo} + 16'd60;
    wr(`TCR_OFF_CMP_BASE, tgt[15:8]);
    wr(`TCR_OFF_CMP_BASE + 5'd1, tgt[7:0]);
    wr(`TCR_OFF_CH_EN, 8'h80);
    repeat (80) @(posedge i_clk);
    #1 chk({3'b000, o_oc_pin}, 8'h15);
    rd(`TCR_OFF_CH_FLG, 8'h80, 8'h80);
    chk({7'h00, o_irq_chan}, 8'h01);
    wr(`TCR_OFF_CH_FLG, 8'h00);
    rd(`TCR_OFF_CH_FLG, 8'h80, 8'h80);
    wr(`TCR_OFF_CH_EN, 8'h00);
    #1 chk({7'h00, o_irq_chan}, 8'h00);
    wr(`TCR_OFF_CH_FLG, 8'h80);
    rd(`TCR_OFF_CH_FLG, 8'h00, 8'h80);
    wr(`TCR_OFF_MPMASK, 8'h00);
    wr(`TCR_OFF_ACC_CTL, 8'h04);
    wr(`TCR_OFF_ACTION, 8'hE6);
    // Channel 4 toggles, so it is left to a real match, not a force.
    wr(`TCR_OFF_FORCE, 8'h68);
    repeat (4) @(posedge i_clk);
    #1 chk({3'b000, o_oc_pin}, 8'h19);
    chk({3'b000, o_oc_pin_oe}, 8'h0E);
    rd(`TCR_OFF_CH_FLG, 8'h00, 8'h78);
    wr(`TCR_OFF_CMP_BASE + 5'd6, 8'h00);
    wr(`TCR_OFF_CMP_BASE + 5'd7, 8'hC8);
    wait_cyc(210);
    #1 chk({3'b000, o_oc_pin}, 8'h1B);
    rd(`TCR_OFF_CH_FLG, 8'h10, 8'h10);
    @(posedge i_clk);
    i_cap_event <= 4'hF;
    @(posedge i_clk);
    i_cap_event <= 4'h0;
    rd(`TCR_OFF_CH_FLG, 8'h0F, 8'h0F);
    wr(`TCR_OFF_CH_EN, 8'h08);
    #1 chk({7'h00, o_irq_chan}, 8'h01);
    wr(`TCR_OFF_CH_FLG, 8'h0F);
    #1 chk({7'h00, o_irq_chan}, 8'h00);
    wait_cyc(8180);
    rd(`TCR_OFF_MISC_FLG, 8'h00, 8'h40);
    wait_cyc(8210);
    rd(`TCR_OFF_MISC_FLG, 8'h40, 8'h40);
    chk({7'h00, o_irq_rti}, 8'h01);
    wr(`TCR_OFF_MISC_FLG, 8'h40);
    rd(`TCR_OFF_MISC_FLG, 8'h00, 8'h40);
    wait_cyc(16370);
    rd(`TCR_OFF_MISC_FLG, 8'h00, 8'h40);
    wait_cyc(16400);
    rd(`TCR_OFF_MISC_FLG, 8'h40, 8'h40);
    wait_cyc(65500);
    rd(`TCR_OFF_MISC_FLG, 8'h00, 8'h80);
    wait_cyc(65560);
    rd(`TCR_OFF_MISC_FLG, 8'h80, 8'h80);
    chk({7'h00, o_irq_ovf}, 8'h01);
    wr(`TCR_OFF_MISC_FLG, 8'h00);
    wr(`TCR_OFF_MISC_FLG, 8'hC0);
    rd(`TCR_OFF_MISC_FLG, 8'h00, 8'hC0);
    wr(`TCR_OFF_MISC_EN, 8'h00);
    #1 chk({6'h00, o_irq_ovf, o_irq_rti}, 8'h00);
    // Special mode reopens the prescale field; codes 1 to 3 are each timed
    // over 64 clocks, a whole number of ticks for every divider.
    @(posedge i_clk);
    i_special_mode <= 1'b1;
    for (int p = 1; p < 4; p++) begin
      wr(`TCR_OFF_MISC_EN, {6'h00, p[1:0]});
      rd_val(`TCR_OFF_CNT_LO, lo);
      repeat (62) @(posedge i_clk);
      rd_val(`TCR_OFF_CNT_LO, lo2);
      chk(lo2 - lo, 8'h20 >> p);
    end
    stop_test;
  end
endmodule // test_timer_compare_rti
`default_nettype wire
